// ==== eqcrb_pkg.sv ====
// constants shared by the equalizer control register bank
// assumes the serial pins are already synchronous to ref_clk_i
`default_nettype none

package eqcrb_pkg;

	// register indices on the serial port
	localparam logic [6:0] EQCRB_ADDR_GEN_CTRL = 7'h00;
	localparam logic [6:0] EQCRB_ADDR_DRV_SETUP = 7'h01;
	localparam logic [6:0] EQCRB_ADDR_LAUNCH = 7'h02;
	localparam logic [6:0] EQCRB_ADDR_CABLE_LEN = 7'h06;

	// frame layout, most significant bit first
	localparam int EQCRB_FRAME_BITS = 16;
	localparam int EQCRB_DIR_BIT = 15;
	localparam int EQCRB_ADDR_MSB = 14;
	localparam int EQCRB_ADDR_LSB = 8;
	localparam logic [4:0] EQCRB_FRAME_COUNT = 5'h10;

	// general control fields
	localparam int EQCRB_GC_CARRIER = 7;
	localparam int EQCRB_GC_MUTE = 6;
	localparam int EQCRB_GC_BYPASS = 5;
	localparam int EQCRB_GC_SLEEP_MSB = 4;
	localparam int EQCRB_GC_SLEEP_LSB = 3;
	localparam int EQCRB_GC_DRV_SEL = 2;
	localparam int EQCRB_GC_MASTER_RST = 1;
	localparam int EQCRB_GC_ACQ_RST = 0;
	localparam logic [6:0] EQCRB_GC_RESET = 7'h08;

	// sleep policy codes
	typedef enum logic [1:0] {
		EQCRB_SLEEP_NEVER = 2'h0,
		EQCRB_SLEEP_AUTO = 2'h1,
		EQCRB_SLEEP_FORCE = 2'h2,
		EQCRB_SLEEP_RSVD = 2'h3
	} eqcrb_sleep_t;

	// output driver fields; bit 0 is reserved and reads zero
	localparam int EQCRB_DRV_SWING_LSB = 6;
	localparam int EQCRB_DRV_OFFSET_LSB = 4;
	localparam int EQCRB_DRV_DEEMPH_EN = 3;
	localparam int EQCRB_DRV_DEEMPH_LSB = 1;
	localparam logic [7:0] EQCRB_DRV_RESET = 8'ha2;
	localparam logic [1:0] EQCRB_OFFSET_SUPPLY = 2'h3;

	// launch amplitude field
	localparam int EQCRB_LAUNCH_BIT = 7;
	localparam logic EQCRB_LAUNCH_RESET = 1'b0;

	// cable length reading range and scale, in quarter metres
	localparam logic [7:0] EQCRB_CLEN_MAX = 8'hf7;
	localparam logic [7:0] EQCRB_CLEN_KNEE = 8'hbf;
	localparam logic [10:0] EQCRB_CLEN_FINE_STEP = 11'h005;
	localparam logic [10:0] EQCRB_CLEN_COARSE_STEP = 11'h00f;

endpackage : eqcrb_pkg

`default_nettype wire

// ==== eqcrb_regbank.sv ====
// control and status register bank with its serial slave port
// assumes sck, ss and mosi are synchronous to ref_clk_i and that sck
// runs well below half the ref_clk_i rate
`default_nettype none

module eqcrb_regbank
	import eqcrb_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// serial port
	input wire logic ss_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// status from the analog equalizer
	input wire logic carrier_detect_i,
	input wire logic [7:0] cable_length_i,
	// equalizer controls
	output logic eq_mute_o,
	output logic eq_bypass_o,
	output logic eq_sleep_o,
	output logic acq_rst_o,
	output logic launch_atten_o,
	output logic [10:0] cable_length_qm_o,
	// output_pair_zero settings
	output logic [1:0] pair0_swing_o,
	output logic [1:0] pair0_offset_o,
	output logic pair0_supply_ref_o,
	output logic pair0_deemph_en_o,
	output logic [1:0] pair0_deemph_lvl_o,
	// output_pair_one settings
	output logic [1:0] pair1_swing_o,
	output logic [1:0] pair1_offset_o,
	output logic pair1_supply_ref_o,
	output logic pair1_deemph_en_o,
	output logic [1:0] pair1_deemph_lvl_o
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// clamps the raw reading to the documented range
	function automatic logic [7:0] clamp_len(input logic [7:0] raw);
		clamp_len = (raw > EQCRB_CLEN_MAX) ? EQCRB_CLEN_MAX : raw;
	endfunction : clamp_len

	// converts a code into quarter metres; two slopes meet at the knee
	// quarter metres keep both slopes in integers: 5 and 15 per count
	function automatic logic [10:0] len_to_qm(input logic [7:0] code);
		logic [10:0] c;
		c = {3'h0, code};
		if (code <= EQCRB_CLEN_KNEE) begin
			len_to_qm = 11'(c * EQCRB_CLEN_FINE_STEP);
		end else begin
			len_to_qm = 11'({3'h0, EQCRB_CLEN_KNEE} * EQCRB_CLEN_FINE_STEP
				+ (c - {3'h0, EQCRB_CLEN_KNEE}) * EQCRB_CLEN_COARSE_STEP);
		end
	endfunction : len_to_qm

	////////////////////////////////////////////////////////////////////////////
	// pin edge detection

	logic sck_q, sck_d;
	logic ss_n_q, ss_n_d;
	logic sck_rise, sck_fall, ss_fall, ss_rise;

	// previous pin levels, one stage is enough since pins are synchronous
	always_comb begin
		sck_d = sck_i;
		ss_n_d = ss_n_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sck_q <= 1'b0;
			ss_n_q <= 1'b1;
		end else begin
			sck_q <= sck_d;
			ss_n_q <= ss_n_d;
		end
	end

	// edges count only while selected, so sck noise between frames is ignored
	assign sck_rise = !ss_n_i && sck_i && !sck_q;
	assign sck_fall = !ss_n_i && !sck_i && sck_q;
	assign ss_fall = !ss_n_i && ss_n_q;
	assign ss_rise = ss_n_i && !ss_n_q;

	////////////////////////////////////////////////////////////////////////////
	// register state

	logic [6:0] gc_q, gc_d;
	// bit 0 of the driver copies is reserved and reads zero, so it is not stored
	logic [7:1] drv_q [2];
	logic [7:1] drv_d [2];
	logic launch_q, launch_d;
	logic [15:0] shift_q, shift_d;
	logic [4:0] bits_q, bits_d;
	logic acq_q, acq_d;
	logic miso_q, miso_d;
	logic miso_oe_q, miso_oe_d;

	// decoded fields of the frame now sitting in the shifter
	logic frame_done;
	logic frame_rd;
	logic [6:0] frame_addr;
	logic [7:0] frame_data;
	logic bank;
	logic [7:0] rd_byte;
	logic soft_rst;

	// a frame commits only on the select rising edge after a full 16 clocks;
	// short frames are dropped, so a glitch on select cannot write anything
	assign frame_done = ss_rise && (bits_q >= EQCRB_FRAME_COUNT);
	assign frame_rd = shift_q[EQCRB_DIR_BIT];
	assign frame_addr = shift_q[EQCRB_ADDR_MSB:EQCRB_ADDR_LSB];
	assign frame_data = shift_q[7:0];
	assign bank = gc_q[EQCRB_GC_DRV_SEL];
	// a master reset write lands at the frame end and clears on the next edge
	assign soft_rst = gc_q[EQCRB_GC_MASTER_RST];

	// read mux; carrier and cable length are live, writes cannot touch them
	always_comb begin
		unique case (frame_addr)
			EQCRB_ADDR_GEN_CTRL: rd_byte = {carrier_detect_i, gc_q};
			EQCRB_ADDR_DRV_SETUP: rd_byte = {drv_q[bank], 1'b0};
			EQCRB_ADDR_LAUNCH: rd_byte = {launch_q, 7'h00};
			EQCRB_ADDR_CABLE_LEN: rd_byte = clamp_len(cable_length_i);
			default: rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// serial shifter and frame commit

	// shifting keeps the last 16 bits, so long daisy-chain frames just pass
	// the earlier bits on through miso
	always_comb begin
		shift_d = shift_q;
		bits_d = bits_q;
		miso_d = miso_q;
		miso_oe_d = !ss_n_i;
		if (ss_fall) begin
			bits_d = 5'h00;
			miso_d = shift_q[EQCRB_FRAME_BITS-1];
		end
		if (sck_rise) begin
			shift_d = {shift_q[14:0], mosi_i};
			if (bits_q != EQCRB_FRAME_COUNT) begin
				bits_d = 5'(bits_q + 5'h01);
			end
		end
		if (sck_fall) begin
			miso_d = shift_q[EQCRB_FRAME_BITS-1];
		end
		if (frame_done && frame_rd) begin
			shift_d = {shift_q[15:8], rd_byte};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			shift_q <= 16'h0000;
			bits_q <= 5'h00;
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			bits_q <= bits_d;
			miso_q <= miso_d;
			miso_oe_q <= miso_oe_d;
		end
	end

	// register writes happen only when a whole frame ends with ss rising
	always_comb begin
		gc_d = gc_q;
		drv_d = drv_q;
		launch_d = launch_q;
		// the acquisition bit clears itself and leaves a one-cycle pulse behind
		acq_d = 1'b0;
		gc_d[EQCRB_GC_ACQ_RST] = 1'b0;
		if (gc_q[EQCRB_GC_ACQ_RST]) begin
			acq_d = 1'b1;
		end
		if (frame_done && !frame_rd) begin
			unique case (frame_addr)
				EQCRB_ADDR_GEN_CTRL: begin
					gc_d = frame_data[6:0];
				end
				EQCRB_ADDR_DRV_SETUP: begin
					drv_d[bank] = frame_data[7:1];
				end
				EQCRB_ADDR_LAUNCH: begin
					launch_d = frame_data[EQCRB_LAUNCH_BIT];
				end
				default: begin
					// cable length and unmapped writes are dropped
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			gc_q <= EQCRB_GC_RESET;
			drv_q[0] <= EQCRB_DRV_RESET[7:1];
			drv_q[1] <= EQCRB_DRV_RESET[7:1];
			launch_q <= EQCRB_LAUNCH_RESET;
			acq_q <= 1'b0;
		end else begin
			gc_q <= gc_d;
			drv_q <= drv_d;
			launch_q <= launch_d;
			acq_q <= acq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// equalizer control outputs

	logic sleep_act;
	eqcrb_sleep_t sleep_mode;
	logic mute_q, mute_d, bypass_q, bypass_d, sleep_q, sleep_d;
	logic launch_o_q, launch_o_d;
	logic [10:0] clen_q, clen_d;

	assign sleep_mode = eqcrb_sleep_t'(gc_q[EQCRB_GC_SLEEP_MSB:EQCRB_GC_SLEEP_LSB]);

	// reserved sleep code is treated as never sleep; the host must not use it
	always_comb begin
		unique case (sleep_mode)
			EQCRB_SLEEP_NEVER: sleep_act = 1'b0;
			EQCRB_SLEEP_AUTO: sleep_act = !carrier_detect_i;
			EQCRB_SLEEP_FORCE: sleep_act = 1'b1;
			EQCRB_SLEEP_RSVD: sleep_act = 1'b0;
		endcase
	end

	// precedence: sleep over mute over bypass
	always_comb begin
		sleep_d = sleep_act;
		mute_d = gc_q[EQCRB_GC_MUTE] && !sleep_act;
		bypass_d = gc_q[EQCRB_GC_BYPASS] && !gc_q[EQCRB_GC_MUTE] && !sleep_act;
		launch_o_d = launch_q;
		clen_d = len_to_qm(clamp_len(cable_length_i));
	end

	// these flops ignore the master reset bit; they follow the registers one
	// cycle later anyway, so a master reset still settles them in two cycles
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sleep_q <= 1'b0;
			mute_q <= 1'b0;
			bypass_q <= 1'b0;
			launch_o_q <= 1'b0;
			clen_q <= 11'h000;
		end else begin
			sleep_q <= sleep_d;
			mute_q <= mute_d;
			bypass_q <= bypass_d;
			launch_o_q <= launch_o_d;
			clen_q <= clen_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-pair driver settings

	logic [7:0] pair_q [2];
	logic [7:0] pair_d [2];

	// bit 0 of each entry carries the supply reference flag
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			pair_d[p] = {drv_q[p],
				drv_q[p][EQCRB_DRV_OFFSET_LSB+1:EQCRB_DRV_OFFSET_LSB]
				== EQCRB_OFFSET_SUPPLY};
		end
	end

	// pair outputs lag the register copy by one cycle, the same as the other controls
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pair_q[0] <= 8'h00;
			pair_q[1] <= 8'h00;
		end else begin
			pair_q <= pair_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign miso_o = miso_q;
	assign miso_oe_o = miso_oe_q;
	assign eq_mute_o = mute_q;
	assign eq_bypass_o = bypass_q;
	assign eq_sleep_o = sleep_q;
	assign acq_rst_o = acq_q;
	assign launch_atten_o = launch_o_q;
	assign cable_length_qm_o = clen_q;

	// field slices of the registered copies; no logic after the flops
	assign pair0_swing_o = pair_q[0][7:6];
	assign pair0_offset_o = pair_q[0][5:4];
	assign pair0_deemph_en_o = pair_q[0][3];
	assign pair0_deemph_lvl_o = pair_q[0][2:1];
	assign pair0_supply_ref_o = pair_q[0][0];

	assign pair1_swing_o = pair_q[1][7:6];
	assign pair1_offset_o = pair_q[1][5:4];
	assign pair1_deemph_en_o = pair_q[1][3];
	assign pair1_deemph_lvl_o = pair_q[1][2:1];
	assign pair1_supply_ref_o = pair_q[1][0];

endmodule : eqcrb_regbank

`default_nettype wire

// ==== eqcrb_spi_host.sv ====
// serial host model: 16-bit frames, msb first, sck phases of two clocks
// assumes the bench clock is ref_clk_i and miso floats outside frames
`default_nettype none
module eqcrb_spi_host (
	// clock and returned data
	input wire logic clk_i,
	input wire logic miso_i,
	// serial lines towards the device
	output logic ss_n_o,
	output logic sck_o,
	output logic mosi_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle: deselected, sck parked low
	initial begin
		ss_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b1;
	end
	// one frame; miso taken just before each rise, where it has settled
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk_i);
		ss_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = tx[i];
			repeat (2) @(negedge clk_i);
			rx = {rx[14:0], miso_i};
			sck_o = 1'b1;
			repeat (2) @(negedge clk_i);
			sck_o = 1'b0;
		end
		repeat (2) @(negedge clk_i);
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o; // released line never shows the last bit
		repeat (4) @(negedge clk_i);
	endtask : xfer
	// read: command frame, then an all-ones frame that carries the byte out
	task automatic rd(input logic [6:0] a, output logic [15:0] rx);
		xfer({1'b1, a, 8'hff}, rx);
		xfer(16'hffff, rx);
	endtask : rd
endmodule : eqcrb_spi_host
`default_nettype wire

// ==== eqcrb_regbank_asserts.sv ====
// port checker for the register bank
// bound to every eqcrb_regbank instance; single clock domain
`default_nettype none
module eqcrb_regbank_asserts (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// serial port
	input wire logic ss_n_i,
	input wire logic miso_oe_o,
	// status and controls
	input wire logic [7:0] cable_length_i,
	input wire logic [10:0] cable_length_qm_o,
	input wire logic eq_mute_o,
	input wire logic eq_bypass_o,
	input wire logic eq_sleep_o,
	input wire logic acq_rst_o,
	input wire logic launch_atten_o,
	// pair settings
	input wire logic [1:0] pair0_offset_o,
	input wire logic pair0_supply_ref_o,
	input wire logic [1:0] pair1_offset_o,
	input wire logic pair1_supply_ref_o,
	input wire logic [1:0] pair1_deemph_lvl_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// length in quarter metres, clamped first so codes above range cannot overflow
	function automatic logic [10:0] qm(input logic [7:0] c);
		logic [7:0] k;
		k = (c > 8'hf7) ? 8'hf7 : c;
		return (k > 8'hbf) ? 11'h3bb + 11'(k - 8'hbf) * 11'h00f : 11'(k) * 11'h005;
	endfunction : qm
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_oe_lag: assert property (1'b1 |=> miso_oe_o == !$past(ss_n_i))
		else $error("miso enable does not follow select");
	a_oe_idle: assert property (ss_n_i [*2] |-> !miso_oe_o)
		else $error("miso driven while deselected");
	a_mute_wins: assert property (eq_mute_o |-> !eq_bypass_o)
		else $error("bypass active under mute");
	a_sleep_wins: assert property (eq_sleep_o |-> !(eq_mute_o || eq_bypass_o))
		else $error("mute or bypass active while asleep");
	a_supply_zero: assert property (pair0_supply_ref_o == (pair0_offset_o == 2'h3))
		else $error("pair zero supply reference wrong");
	a_supply_one: assert property (pair1_supply_ref_o == (pair1_offset_o == 2'h3))
		else $error("pair one supply reference wrong");
	a_clen_scale: assert property (1'b1 |=> cable_length_qm_o == qm($past(cable_length_i)))
		else $error("length scale wrong");
	a_acq_pulse: assert property (acq_rst_o |=> !acq_rst_o)
		else $error("acquisition reset longer than one cycle");
	a_launch_quiet: assert property ($changed(launch_atten_o) |-> $past(ss_n_i))
		else $error("launch setting moved inside a frame");
	a_level_quiet: assert property ($changed(pair1_deemph_lvl_o) |-> $past(ss_n_i))
		else $error("level moved inside a frame");
endmodule : eqcrb_regbank_asserts
bind eqcrb_regbank eqcrb_regbank_asserts chk_i (.*);
`default_nettype wire

// ==== tb_equalizer_control_register_bank.sv ====
// self-checking bench for the register bank
// serial traffic comes from the host model; analog status is driven here
`default_nettype none
module tb_equalizer_control_register_bank;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic carrier_detect_i = 1'b0;
	logic [7:0] cable_length_i = 8'h00;
	wire logic ss_n_i, sck_i, mosi_i, miso_o, miso_oe_o, eq_mute_o, eq_bypass_o, eq_sleep_o;
	wire logic acq_rst_o, launch_atten_o, pair0_supply_ref_o, pair1_supply_ref_o;
	wire logic pair0_deemph_en_o, pair1_deemph_en_o;
	wire logic [1:0] pair0_swing_o, pair0_offset_o, pair0_deemph_lvl_o;
	wire logic [1:0] pair1_swing_o, pair1_offset_o, pair1_deemph_lvl_o;
	wire logic [10:0] cable_length_qm_o;
	wire logic [7:0] p0 = {pair0_swing_o, pair0_offset_o, pair0_deemph_en_o, pair0_deemph_lvl_o, 1'b0};
	wire logic [7:0] p1 = {pair1_swing_o, pair1_offset_o, pair1_deemph_en_o, pair1_deemph_lvl_o, 1'b0};
	int mismatches = 0;
	int check_count = 0;
	int acq_pulses = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	eqcrb_regbank dut (.*);
	// a deselected miso shows the inverse, so a late enable cannot pass unseen
	eqcrb_spi_host host (.clk_i(ref_clk_i), .miso_i(miso_oe_o ? miso_o : ~miso_o), .ss_n_o(ss_n_i),
		.sck_o(sck_i), .mosi_o(mosi_i));
	// one-cycle pulses are counted between edges, while they stand
	always @(negedge ref_clk_i) begin
		if (acq_rst_o === 1'b1) begin
			acq_pulses++;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		host.xfer({1'b0, a, d}, r);
	endtask : wr
	// the echoed header proves the byte sits in the last eight bit times
	task automatic rdc(input string n, input logic [6:0] a, input logic [7:0] e);
		logic [15:0] r;
		host.rd(a, r);
		chk(n, r, {1'b1, a, e});
	endtask : rdc
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdc("gc", 7'h00, 8'h08);
		rdc("drv", 7'h01, 8'ha2);
		rdc("launch", 7'h02, 8'h00);
		chk("p0", 16'(p0), 16'h00a2);
		chk("sleep", 16'(eq_sleep_o), 16'h0001);
	endtask : t_reset
	// every swing, offset and level code on pair one with de-emphasis enable held at one, pair zero left alone
	task automatic t_bank();
		wr(7'h01, 8'h22);
		wr(7'h00, 8'h04);
		for (int i = 0; i < 4; i++) begin
			wr(7'h01, {2'(i), 2'(i), 1'b1, 2'(i), 1'b0});
			chk("p1", 16'(p1), 16'({2'(i), 2'(i), 1'b1, 2'(i), 1'b0}));
			chk("sr1", 16'(pair1_supply_ref_o), 16'(i == 3));
		end
		rdc("drv1", 7'h01, 8'hfe);
		wr(7'h00, 8'h00);
		chk("p0", 16'(p0), 16'h0022);
		rdc("drv0", 7'h01, 8'h22);
	endtask : t_bank
	task automatic t_ctrl();
		wr(7'h00, 8'h20);
		chk("msb", 16'({eq_mute_o, eq_bypass_o, eq_sleep_o}), 16'h0002);
		wr(7'h00, 8'h60);
		chk("msb", 16'({eq_mute_o, eq_bypass_o, eq_sleep_o}), 16'h0004);
		wr(7'h00, 8'h70);
		chk("msb", 16'({eq_mute_o, eq_bypass_o, eq_sleep_o}), 16'h0001);
		wr(7'h00, 8'h88);
		rdc("gc", 7'h00, 8'h08);
		carrier_detect_i = 1'b1;
		rdc("gc", 7'h00, 8'h88);
		chk("sleep", 16'(eq_sleep_o), 16'h0000);
	endtask : t_ctrl
	task automatic t_clen();
		cable_length_i = 8'hc8;
		wr(7'h06, 8'h00);
		rdc("clen", 7'h06, 8'hc8);
		chk("qm", 16'(cable_length_qm_o), 16'h0442);
		cable_length_i = 8'hfa;
		rdc("clamp", 7'h06, 8'hf7);
		chk("qm", 16'(cable_length_qm_o), 16'h0703);
		cable_length_i = 8'h64;
		rdc("clen", 7'h06, 8'h64);
		chk("qm", 16'(cable_length_qm_o), 16'h01f4);
		cable_length_i = 8'h00;
	endtask : t_clen
	task automatic t_resets();
		wr(7'h00, 8'h09);
		rdc("acq", 7'h00, 8'h88);
		chk("acqn", 16'(acq_pulses), 16'h0001);
		wr(7'h01, 8'h00);
		wr(7'h02, 8'h80);
		chk("lau", 16'(launch_atten_o), 16'h0001);
		wr(7'h00, 8'h02);
		rdc("mrst", 7'h01, 8'ha2);
		chk("lau", 16'(launch_atten_o), 16'h0000);
	endtask : t_resets
	// a mid-run system reset clears outputs while held and restores defaults
	task automatic t_sysrst();
		wr(7'h02, 8'h80);
		wr(7'h00, 8'h20);
		chk("byp", 16'(eq_bypass_o), 16'h0001);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		chk("rp0", 16'(p0), 16'h0000);
		chk("rlau", 16'(launch_atten_o), 16'h0000);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		chk("rp0", 16'(p0), 16'h00a2);
		chk("rbyp", 16'(eq_bypass_o), 16'h0000);
		rdc("rgc", 7'h00, 8'h88);
	endtask : t_sysrst
	initial begin
		repeat (12) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		t_reset();
		t_bank();
		t_ctrl();
		t_clen();
		t_resets();
		t_sysrst();
		end_of_test();
	end
endmodule : tb_equalizer_control_register_bank
`default_nettype wire
